// File: core/src_pkg.sv
/*
 * src_pkg: shared constants for the sync receive crc checker.
 * assumes a 32-bit ahb-lite register bus, one word per register.
 */
`default_nettype none

package src_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_COMMAND      = 8'h00;  // command_reg
    localparam logic [7:0] OFS_RX_CONTROL   = 8'h04;  // rx_control_reg
    localparam logic [7:0] OFS_MODE_SELECT  = 8'h08;  // mode_select_reg
    localparam logic [7:0] OFS_TX_CONTROL   = 8'h0C;  // tx_control_reg
    localparam logic [7:0] OFS_SYNC_LOW     = 8'h10;  // sync_pattern_low_reg
    localparam logic [7:0] OFS_SYNC_HIGH    = 8'h14;  // sync_pattern_high_reg
    localparam logic [7:0] OFS_MISC_LINE    = 8'h18;  // misc_line_control_reg
    localparam logic [7:0] OFS_LINE_STATUS  = 8'h1C;  // line_status_reg (ro)
    localparam logic [7:0] OFS_SPECIAL_STAT = 8'h20;  // special_rx_status_reg (ro)
    localparam logic [7:0] OFS_RX_DATA      = 8'h24;  // receive data (ro, pops)
    localparam logic [7:0] OFS_PIN_SELECT   = 8'h28;  // terminal pin function select

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CMD_CODE_HI      = 7;   // command code field [7:6]
    localparam int CMD_ERR_HI       = 5;   // error command field [5:3]
    localparam int RXC_LEN_HI       = 7;   // bits per char [7:6]
    localparam int RXC_AUTO_EN      = 5;   // auto enable
    localparam int RXC_HUNT         = 4;   // enter hunt command
    localparam int RXC_CRC_EN       = 3;   // rx crc enable
    localparam int RXC_STRIP        = 1;   // sync character load inhibit
    localparam int RXC_RX_EN        = 0;   // receiver enable
    localparam int MODE_SYNC16      = 4;   // 16-bit sync select
    localparam int TXC_TERM_READY   = 7;   // terminal ready bit
    localparam int TXC_POLY_SEL     = 2;   // 1 = crc-16, 0 = crc-ccitt
    localparam int MISC_PRESET      = 7;   // 1 = preset ones
    localparam int LS_RX_AVAIL      = 0;
    localparam int LS_CARRIER       = 3;
    localparam int LS_HUNT          = 4;
    localparam int SS_OVERRUN       = 5;
    localparam int SS_CRC_ERR       = 6;

    // ------------------------------------------------------------
    // codes and reset values
    // ------------------------------------------------------------
    localparam logic [1:0]  CMD_RESET_RX_CRC = 2'h1;
    localparam logic [2:0]  CMD_ERROR_RESET  = 3'h6;
    localparam logic [7:0]  REG_RESET        = 8'h00;
    localparam logic [15:0] POLY_CRC16       = 16'h8005;
    localparam logic [15:0] POLY_CCITT       = 16'h1021;
    localparam logic [3:0]  SYNC_STAGES      = 4'h2;

    // bits per character from the two length bits
    function automatic logic [3:0] char_bits(input logic [1:0] sel);
        case (sel)
            2'h0:    char_bits = 4'h5;
            2'h1:    char_bits = 4'h7;
            2'h2:    char_bits = 4'h6;
            default: char_bits = 4'h8;
        endcase
    endfunction : char_bits
endpackage : src_pkg

`default_nettype wire

// File: core/src_crc_unit.sv
/*
 * src_crc_unit: serial crc-16 / crc-ccitt checker register.
 * assumes one data bit per enabled cycle, msb-first polynomial form.
 */
`default_nettype none

module src_crc_unit
    import src_pkg::*;
(
    input  wire logic        hclk,        // system clock
    input  wire logic        hresetn,     // async reset, active low
    input  wire logic        preset,      // load start value
    input  wire logic        preset_ones, // start value all ones
    input  wire logic        poly_sel,    // 1 = crc-16
    input  wire logic        bit_en,      // accumulate din this cycle
    input  wire logic        din,         // serial data bit
    output logic      [15:0] crc          // current remainder
);
    logic [15:0] crc_reg;   // remainder
    logic [15:0] crc_next;  // next remainder
    logic        feedback;  // top bit xor data

    // ------------------------------------------------------------
    // next-state arithmetic
    // ------------------------------------------------------------
    always_comb begin
        feedback = crc_reg[15] ^ din;
        crc_next = {crc_reg[14:0], 1'b0};
        if (feedback) begin
            crc_next = crc_next ^ (poly_sel ? POLY_CRC16 : POLY_CCITT);
        end
    end

    // preset has priority over accumulation
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            crc_reg <= 16'h0000;
        end else if (preset) begin
            crc_reg <= preset_ones ? 16'hFFFF : 16'h0000;
        end else if (bit_en) begin
            crc_reg <= crc_next;
        end
    end

    assign crc = crc_reg;
endmodule : src_crc_unit

`default_nettype wire

// File: core/src_rx_crc_top.sv
/*
 * src_rx_crc_top: byte-synchronous receiver with selective crc checking,
 * modem pins and an ahb-lite register slave.
 * assumes rx clock, rx data and carrier pins are asynchronous to hclk and
 * much slower than it; a single master drives the ahb-lite bus.
 */
// Chosen here: the AHB-Lite register port and the register offsets.
`default_nettype none

module src_rx_crc_top
    import src_pkg::*;
(
    input  wire logic        hclk,              // system clock
    input  wire logic        hresetn,           // async reset, active low
    input  wire logic        hsel,              // slave select
    input  wire logic [31:0] haddr,             // byte address
    input  wire logic [1:0]  htrans,            // transfer type
    input  wire logic        hwrite,            // write transfer
    input  wire logic [2:0]  hsize,             // transfer size
    input  wire logic [31:0] hwdata,            // write data
    input  wire logic        hready,            // bus ready in
    output logic      [31:0] hrdata,            // read data
    output logic             hreadyout,         // slave ready
    output logic             hresp,             // response, always okay
    input  wire logic        rx_clk_pin,        // receive bit clock
    input  wire logic        rx_data_pin,       // receive serial data
    input  wire logic        carrier_detect_pin,// carrier, active low
    input  wire logic        tx_dma_req,        // transmit dma request
    output logic             term_ready_pin     // terminal ready / request
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]  rx_control_reg;      // receive control
    logic [7:0]  mode_select_reg;     // mode select
    logic [7:0]  tx_control_reg;      // transmit control
    logic [7:0]  sync_pattern_low_reg;  // sync pattern low
    logic [7:0]  sync_pattern_high_reg; // sync pattern high
    logic [7:0]  misc_line_control_reg; // misc control
    logic        pin_select_reg;      // 1 = pin carries dma request
    logic [2:0]  clk_sync_reg;        // rx clock sync and edge stage
    logic [1:0]  data_sync_reg;       // rx data sync
    logic [1:0]  cd_sync_reg;         // carrier sync
    logic        hunt_reg;            // receiver hunting
    logic        rx_en_d_reg;         // previous receiver enable
    logic [15:0] shift_reg;           // receive shift register
    logic [3:0]  bit_cnt_reg;         // bits assembled
    logic [7:0]  pend_reg;            // last loaded character
    logic [7:0]  delay_reg;           // crc delay stage
    logic [3:0]  delay_cnt_reg;       // delay bits left to feed
    logic        crc_active_reg;      // crc enable applied at load
    logic        first_done_reg;      // a character has been loaded
    logic [7:0]  rx_data_reg;         // receive data holding
    logic        rx_avail_reg;        // data waiting
    logic        crc_err_reg;         // latched crc error
    logic        overrun_reg;         // load while data waiting
    logic [31:0] hrdata_reg;          // registered read data
    logic        wr_pend_reg;         // write data phase pending
    logic [7:0]  wr_addr_reg;         // write address

    logic        bit_tick;            // rising rx clock edge
    logic        rx_run;              // receiver running
    logic        carrier_high;        // carrier pin high (inactive)
    logic [3:0]  nbits;               // bits per character
    logic        char_done;           // character complete
    logic [7:0]  char_data;           // right-justified character
    logic        strip_hit;           // character is a stripped sync
    logic        load;                // load into data holding
    logic        sync_match;          // hunt pattern found
    logic        rd_take;             // read address phase taken
    logic        wr_do;               // write data phase
    logic        hunt_cmd;            // enter hunt requested
    logic        crc_cmd;             // reset crc command
    logic        err_cmd;             // error reset command
    logic        crc_preset;          // preset the checker
    logic [15:0] crc_value;           // checker remainder
    logic [15:0] shift_in;            // shift register after this bit

    // ------------------------------------------------------------
    // pin synchronisers and edge detect
    // ------------------------------------------------------------
    // the rx clock edge is found between the second and third stages
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_sync_reg  <= 3'h0;
            data_sync_reg <= 2'h0;
            cd_sync_reg   <= 2'h3;
        end else begin
            clk_sync_reg  <= {clk_sync_reg[1:0], rx_clk_pin};
            data_sync_reg <= {data_sync_reg[0], rx_data_pin};
            cd_sync_reg   <= {cd_sync_reg[0], carrier_detect_pin};
        end
    end

    assign bit_tick     = clk_sync_reg[1] & ~clk_sync_reg[2];
    assign carrier_high = cd_sync_reg[1];
    // auto enable: a high carrier pin stops the receiver
    assign rx_run = rx_control_reg[RXC_RX_EN] &
                    ~(rx_control_reg[RXC_AUTO_EN] & carrier_high);
    assign nbits  = char_bits(rx_control_reg[RXC_LEN_HI -: 2]);

    // ------------------------------------------------------------
    // ahb-lite slave, zero wait states
    // ------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;
    assign rd_take   = hsel & htrans[1] & hready & ~hwrite;
    assign wr_do     = wr_pend_reg;

    // write address capture for the following data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else if (hready) begin
            wr_pend_reg <= hsel & htrans[1] & hwrite;
            wr_addr_reg <= haddr[7:0];
        end
    end

    // read data is registered at the address phase; unmapped reads zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (rd_take) begin
            hrdata_reg <= 32'h0000_0000;
            if (haddr[7:0] == OFS_RX_CONTROL) begin
                hrdata_reg[7:0] <= rx_control_reg;
            end else if (haddr[7:0] == OFS_MODE_SELECT) begin
                hrdata_reg[7:0] <= mode_select_reg;
            end else if (haddr[7:0] == OFS_TX_CONTROL) begin
                hrdata_reg[7:0] <= tx_control_reg;
            end else if (haddr[7:0] == OFS_SYNC_LOW) begin
                hrdata_reg[7:0] <= sync_pattern_low_reg;
            end else if (haddr[7:0] == OFS_SYNC_HIGH) begin
                hrdata_reg[7:0] <= sync_pattern_high_reg;
            end else if (haddr[7:0] == OFS_MISC_LINE) begin
                hrdata_reg[7:0] <= misc_line_control_reg;
            end else if (haddr[7:0] == OFS_PIN_SELECT) begin
                hrdata_reg[0] <= pin_select_reg;
            end else if (haddr[7:0] == OFS_LINE_STATUS) begin
                hrdata_reg[LS_RX_AVAIL] <= rx_avail_reg;
                hrdata_reg[LS_CARRIER]  <= ~carrier_high;
                hrdata_reg[LS_HUNT]     <= hunt_reg;
            end else if (haddr[7:0] == OFS_SPECIAL_STAT) begin
                hrdata_reg[SS_OVERRUN] <= overrun_reg;
                hrdata_reg[SS_CRC_ERR] <= crc_err_reg;
            end else if (haddr[7:0] == OFS_RX_DATA) begin
                hrdata_reg[7:0] <= rx_data_reg;
            end
        end
    end

    // command decodes from the write data phase
    assign hunt_cmd = wr_do & (wr_addr_reg == OFS_RX_CONTROL) & hwdata[RXC_HUNT];
    assign crc_cmd  = wr_do & (wr_addr_reg == OFS_COMMAND) &
                      (hwdata[CMD_CODE_HI -: 2] == CMD_RESET_RX_CRC);
    assign err_cmd  = wr_do & (wr_addr_reg == OFS_COMMAND) &
                      (hwdata[CMD_ERR_HI -: 3] == CMD_ERROR_RESET);

    // writable registers; the hunt bit is a command and is not stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_control_reg        <= REG_RESET;
            mode_select_reg       <= REG_RESET;
            tx_control_reg        <= REG_RESET;
            sync_pattern_low_reg  <= REG_RESET;
            sync_pattern_high_reg <= REG_RESET;
            misc_line_control_reg <= REG_RESET;
            pin_select_reg        <= 1'b0;
        end else if (wr_do) begin
            if (wr_addr_reg == OFS_RX_CONTROL) begin
                rx_control_reg <= hwdata[7:0] & ~(8'h01 << RXC_HUNT);
            end else if (wr_addr_reg == OFS_MODE_SELECT) begin
                mode_select_reg <= hwdata[7:0];
            end else if (wr_addr_reg == OFS_TX_CONTROL) begin
                tx_control_reg <= hwdata[7:0];
            end else if (wr_addr_reg == OFS_SYNC_LOW) begin
                sync_pattern_low_reg <= hwdata[7:0];
            end else if (wr_addr_reg == OFS_SYNC_HIGH) begin
                sync_pattern_high_reg <= hwdata[7:0];
            end else if (wr_addr_reg == OFS_MISC_LINE) begin
                misc_line_control_reg <= hwdata[7:0];
            end else if (wr_addr_reg == OFS_PIN_SELECT) begin
                pin_select_reg <= hwdata[0];
            end
        end
    end

    // terminal pin: inverted ready bit unless it carries dma request
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            term_ready_pin <= 1'b1;
        end else begin
            term_ready_pin <= pin_select_reg ? ~tx_dma_req
                                             : ~tx_control_reg[TXC_TERM_READY];
        end
    end

    // ------------------------------------------------------------
    // character assembly and hunt
    // ------------------------------------------------------------
    assign shift_in   = {data_sync_reg[1], shift_reg[15:1]};
    assign sync_match = mode_select_reg[MODE_SYNC16]
                      ? (shift_in == {sync_pattern_high_reg, sync_pattern_low_reg})
                      : (shift_in[15:8] == sync_pattern_high_reg);
    assign char_done  = bit_tick & rx_run & ~hunt_reg & (bit_cnt_reg == nbits - 4'h1);
    // bits arrive lsb first, so a short character sits high in the byte
    assign char_data  = shift_in[15:8] >> (4'h8 - nbits);
    assign strip_hit  = rx_control_reg[RXC_STRIP] & ~first_done_reg &
                        (char_data == sync_pattern_low_reg);
    assign load       = char_done & ~strip_hit;

    // hunt entry on enable rise or command; leave on sync match
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hunt_reg    <= 1'b1;
            rx_en_d_reg <= 1'b0;
        end else begin
            rx_en_d_reg <= rx_control_reg[RXC_RX_EN];
            if (hunt_cmd || (rx_control_reg[RXC_RX_EN] && !rx_en_d_reg)) begin
                hunt_reg <= 1'b1;
            end else if (hunt_reg && rx_run && bit_tick && sync_match) begin
                hunt_reg <= 1'b0;
            end
        end
    end

    // shift register and bit counter; a stopped receiver drops its partial
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_reg   <= 16'h0000;
            bit_cnt_reg <= 4'h0;
        end else if (!rx_run || hunt_cmd) begin
            bit_cnt_reg <= 4'h0;
        end else if (bit_tick) begin
            shift_reg <= shift_in;
            if (hunt_reg || char_done) begin
                bit_cnt_reg <= 4'h0;
            end else begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // delay stage and crc gating
    // ------------------------------------------------------------
    // each load moves the previous character into the delay stage and samples
    // the enable; the stage feeds the checker at hclk rate, done before next load
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_reg       <= 8'h00;
            delay_reg      <= 8'h00;
            delay_cnt_reg  <= 4'h0;
            crc_active_reg <= 1'b0;
            first_done_reg <= 1'b0;
        end else if (hunt_reg || hunt_cmd) begin
            delay_cnt_reg  <= 4'h0;
            crc_active_reg <= 1'b0;
            first_done_reg <= 1'b0;
        end else if (load) begin
            pend_reg       <= char_data;
            delay_reg      <= pend_reg;
            delay_cnt_reg  <= first_done_reg ? nbits : 4'h0;
            first_done_reg <= 1'b1;
            // without strip the enable waits until a character is loaded
            crc_active_reg <= rx_control_reg[RXC_CRC_EN] &
                              (rx_control_reg[RXC_STRIP] | first_done_reg);
        end else if (delay_cnt_reg != 4'h0) begin
            delay_reg     <= {1'b0, delay_reg[7:1]};
            delay_cnt_reg <= delay_cnt_reg - 4'h1;
        end
    end

    assign crc_preset = hunt_reg | hunt_cmd | crc_cmd;

    src_crc_unit u_crc (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .preset      (crc_preset),
        .preset_ones (misc_line_control_reg[MISC_PRESET]),
        .poly_sel    (tx_control_reg[TXC_POLY_SEL]),
        .bit_en      (crc_active_reg & (delay_cnt_reg != 4'h0)),
        .din         (delay_reg[0]),
        .crc         (crc_value)
    );

    // ------------------------------------------------------------
    // data holding and error status
    // ------------------------------------------------------------
    // a load beats a same-cycle read or error reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_data_reg  <= 8'h00;
            rx_avail_reg <= 1'b0;
            crc_err_reg  <= 1'b0;
            overrun_reg  <= 1'b0;
        end else begin
            if (load) begin
                rx_data_reg  <= char_data;
                rx_avail_reg <= 1'b1;
                crc_err_reg  <= (crc_value != 16'h0000);
            end else if (rd_take && haddr[7:0] == OFS_RX_DATA) begin
                rx_avail_reg <= 1'b0;
            end
            if (load && rx_avail_reg) begin
                overrun_reg <= 1'b1;
            end else if (err_cmd) begin
                overrun_reg <= 1'b0;
            end
        end
    end
endmodule : src_rx_crc_top

`default_nettype wire

// File: tb/src_props.sv
/* port checker for src_rx_crc_top.
   assumes one ahb master with hready tied to hreadyout. */
`default_nettype none
module src_props
    import src_pkg::*;
(
    input wire logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, // bus
    input wire logic [31:0] haddr, hwdata, hrdata,                               // bus words
    input wire logic [1:0]  htrans,                                              // bus type
    input wire logic        carrier_detect_pin, tx_dma_req, term_ready_pin       // pins
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic       rd, wv_reg, psel_reg; // read taken, write data phase, pin select
    logic [7:0] wa_reg, txc_reg;      // write address, tx control shadow
    assign rd = hsel && htrans[1] && hready && !hwrite;
    // shadow of the registers that steer the terminal pin
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wv_reg   <= 1'b0;
            wa_reg   <= 8'h00;
            txc_reg  <= 8'h00;
            psel_reg <= 1'b0;
        end else begin
            wv_reg <= hsel && htrans[1] && hready && hwrite;
            wa_reg <= haddr[7:0];
            if (wv_reg && wa_reg == OFS_TX_CONTROL) txc_reg <= hwdata[7:0];
            if (wv_reg && wa_reg == OFS_PIN_SELECT) psel_reg <= hwdata[0];
        end
    end
    ready_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or okay");
    upper_zero_a: assert property (hrdata[31:8] == 24'h0) else $error("upper read bits set");
    rdata_hold_a: assert property (!rd |=> $stable(hrdata)) else $error("read data moved");
    term_pin_a: assert property (term_ready_pin == ($past(psel_reg) ? !$past(tx_dma_req)
        : !$past(txc_reg[TXC_TERM_READY]))) else $error("terminal pin wrong");
    poly_read_a: assert property (rd && haddr[7:0] == OFS_TX_CONTROL |=>
        (hrdata[7:0] & 8'h84) == ($past(txc_reg) & 8'h84)) else $error("tx control readback");
    hunt_zero_a: assert property (rd && haddr[7:0] == OFS_RX_CONTROL |=>
        !hrdata[RXC_HUNT]) else $error("hunt bit read as one");
    carrier_bit_a: assert property (rd && haddr[7:0] == OFS_LINE_STATUS &&
        carrier_detect_pin == $past(carrier_detect_pin, 4) |=>
        hrdata[LS_CARRIER] == !$past(carrier_detect_pin)) else $error("carrier bit wrong");
    unmapped_zero_a: assert property (rd && haddr[7:0] == 8'h2C |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
endmodule : src_props
bind src_rx_crc_top src_props u_props (.hclk, .hresetn, .hsel, .hwrite, .hready, .hreadyout,
    .hresp, .haddr, .hwdata, .hrdata, .htrans, .carrier_detect_pin, .tx_dma_req, .term_ready_pin);
`default_nettype wire

// File: tb/src_remote_stn.sv
/* remote station: drives the link clock and serial data.
   assumes the bench sends whole characters back to back in a frame. */
`default_nettype none
module src_remote_stn (
    output var logic rx_clk_pin,  // link clock, still between frames
    output var logic rx_data_pin  // serial data, lsb first
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        rx_clk_pin = 1'b0;
        rx_data_pin = 1'b1;
    end
    // one character, data moved away from the sampling edge
    task automatic send_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            rx_data_pin = b[i];
            #62.5 rx_clk_pin = 1'b1;
            #62.5 rx_clk_pin = 1'b0;
        end
    endtask : send_byte
    // released line shows the inverse of its last bit
    task automatic end_frame();
        #62.5 rx_data_pin = ~rx_data_pin;
    endtask : end_frame
endmodule : src_remote_stn
`default_nettype wire

// File: tb/test_sync_receive_crc_checker.sv
/* bench for src_rx_crc_top: three crc frames, then carrier gating.
   assumes src_remote_stn drives the link side. */
`default_nettype none
module test_sync_receive_crc_checker
    import src_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        carrier_detect_pin = 1'b0, tx_dma_req = 1'b0;
    logic        hreadyout, hresp, term_ready_pin, rx_clk_pin, rx_data_pin;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic [7:0]  fr [8];
    logic [7:0]  txc;
    logic [15:0] c;
    int          errors = 0, num_checks = 0;
    src_rx_crc_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rx_clk_pin, .rx_data_pin,
        .carrier_detect_pin, .tx_dma_req, .term_ready_pin);
    src_remote_stn stn (.rx_clk_pin, .rx_data_pin);
    initial begin
        forever #2.5 hclk = ~hclk;
    end
    always @(posedge hclk) tx_dma_req <= ~tx_dma_req;
    // one ahb single transfer: address phase, then data phase
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : xfer
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // crc over one character, fed lsb first into the msb feedback
    function automatic logic [15:0] crc_step(input logic [15:0] s, input logic [7:0] b,
                                             input logic p16);
        for (int i = 0; i < 8; i++)
            s = {s[14:0], 1'b0} ^ ((s[15] ^ b[i]) ? (p16 ? POLY_CRC16 : POLY_CCITT) : 16'h0);
        return s;
    endfunction : crc_step
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    initial begin
        #200000;
        errors++;
        final_report();
    end
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(1, OFS_MODE_SELECT, 0, r);
        xfer(1, OFS_SYNC_LOW, 32'h16, r);
        xfer(1, OFS_SYNC_HIGH, 32'h16, r);
        for (int k = 0; k < 3; k++) begin
            txc = (k == 0) ? 8'h80 : (k == 1) ? 8'h04 : 8'h84;
            xfer(1, OFS_MISC_LINE, (k > 0) ? 32'h80 : 32'h0, r);
            xfer(1, OFS_TX_CONTROL, {24'h0, txc}, r);
            xfer(0, OFS_TX_CONTROL, 0, r);
            chk(r & 32'h84, {24'h0, txc});
            xfer(1, OFS_RX_CONTROL, (k == 1) ? 32'hDB : 32'hD9, r);
            fr = '{8'h16, 8'hA5 ^ k[7:0], 8'h3C, 8'h81, 8'h00, 8'h00, 8'hFF, 8'hFF};
            c = crc_step(crc_step((k == 2) ? 16'hFFFF : 16'h0, fr[1], txc[2]), fr[2], txc[2]);
            fr[4] = {<<{c[15:8]}};
            fr[5] = {<<{c[7:0]}} ^ {7'h0, k == 2};
            fork
                begin
                    #17.3;
                    if (k == 1) stn.send_byte(8'h16);
                    foreach (fr[i]) stn.send_byte(fr[i]);
                    stn.end_frame();
                end
            join_none
            for (int i = 1; i < 8; i++) begin
                do xfer(0, OFS_LINE_STATUS, 0, r); while (r[LS_RX_AVAIL] !== 1'b1);
                if (i == 7) begin
                    xfer(0, OFS_SPECIAL_STAT, 0, r);
                    chk(r & 32'h40, (k == 2) ? 32'h40 : 32'h0);
                end
                xfer(0, OFS_RX_DATA, 0, r);
                chk(r, {24'h0, fr[i]});
                if (k == 1 && i == 1) begin
                    xfer(1, OFS_MISC_LINE, 0, r);
                    xfer(1, OFS_COMMAND, 32'h40, r);
                end
                xfer(1, OFS_RX_CONTROL, (i == 3) ? 32'hC1 : 32'hC9, r);
            end
            wait fork;
            $display("frame %0d done", k);
        end
        xfer(1, OFS_PIN_SELECT, 32'h1, r);
        xfer(1, OFS_RX_CONTROL, 32'hE1, r);
        carrier_detect_pin <= 1'b1;
        stn.send_byte(8'h55);
        stn.end_frame();
        repeat (8) @(posedge hclk);
        xfer(0, OFS_LINE_STATUS, 0, r);
        chk(r & 32'h09, 32'h0);
        carrier_detect_pin <= 1'b0;
        repeat (6) @(posedge hclk);
        xfer(0, OFS_LINE_STATUS, 0, r);
        chk(r & 32'h08, 32'h08);
        xfer(0, 8'h2C, 0, r);
        chk(r, 32'h0);
        $display("carrier gating done");
        final_report();
    end
endmodule : test_sync_receive_crc_checker
`default_nettype wire
